// *** design/selk_pkg.sv ***
// Package: constants and types of the serial lock command logic
package selk_pkg;
    // Instruction opcodes
    localparam logic [7:0] SET_WRITE_LATCH_CMD = 8'h06;
    localparam logic [7:0] CLEAR_WRITE_LATCH_CMD = 8'h04;
    localparam logic [7:0] LOCK_CMD = 8'h01;
    localparam logic [7:0] READ_STATUS_CMD = 8'h05;
    localparam logic [7:0] WRITE_CMD = 8'h02;
    localparam logic [7:0] READ_CMD = 8'h03;
    // Lock select codes
    localparam logic [2:0] NO_ZONE = 3'h0;
    localparam logic [2:0] FIRST_QUARTER_ZONE = 3'h1;
    localparam logic [2:0] SECOND_QUARTER_ZONE = 3'h2;
    localparam logic [2:0] THIRD_QUARTER_ZONE = 3'h3;
    localparam logic [2:0] FOURTH_QUARTER_ZONE = 3'h4;
    localparam logic [2:0] LOWER_HALF_ZONE = 3'h5;
    localparam logic [2:0] LOWEST_PAGE_ZONE = 3'h6;
    localparam logic [2:0] HIGHEST_PAGE_ZONE = 3'h7;
    localparam logic [2:0] LOCK_RST = 3'h0;
    // Array geometry
    localparam int MEM_DEPTH = 1024;
    localparam int PAGE_BYTES = 16;
    // Self-timed write cycle
    localparam int CLK_HZ = 20000000;
    localparam int T_WC_MS = 10;
    localparam int WC_CYCLES = T_WC_MS * (CLK_HZ / 1000);
    localparam int TMR_W = 18;
    typedef enum logic [3:0] {
        ST_OFF = 4'h0,
        ST_OPC = 4'h1,
        ST_ADDR = 4'h3,
        ST_WDATA = 4'h2,
        ST_RDATA = 4'h6,
        ST_STAT = 4'h7,
        ST_LOCK = 4'h5,
        ST_LATCH = 4'h4,
        ST_IGN = 4'hC
    } selk_state_t;
    typedef struct packed {
        logic sck;
        logic cs_n;
        logic si;
        logic wp_n;
    } selk_pins_t;
    // Select resets low so a pin held low through reset is no falling edge
    localparam selk_pins_t PINS_RST = '{sck: 1'h0, cs_n: 1'h0, si: 1'h0, wp_n: 1'h0};
endpackage : selk_pkg

// *** design/selk_serial_lock.sv ***
// Module: serial EEPROM instruction decoder, write latch and area lock
`timescale 1ns/1ps
module selk_serial_lock #(
    parameter int P_WC_CYCLES = selk_pkg::WC_CYCLES
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_sck,
    input wire logic i_cs_n,
    input wire logic i_si,
    input wire logic i_wp_n,
    output logic o_so,
    output logic o_so_oe,
    output logic o_busy,
    output logic o_wel,
    output logic [2:0] o_lock_select_bits
);
    import selk_pkg::*;

    // ------------------------------------------------------------
    // Protection decode
    // ------------------------------------------------------------
    function automatic logic zone_locked(input logic [2:0] sel, input logic [9:0] a);
        logic hit;
        hit = 1'h0;
        case (sel)
            FIRST_QUARTER_ZONE: hit = (a[9:8] == 2'h0);
            SECOND_QUARTER_ZONE: hit = (a[9:8] == 2'h1);
            THIRD_QUARTER_ZONE: hit = (a[9:8] == 2'h2);
            FOURTH_QUARTER_ZONE: hit = (a[9:8] == 2'h3);
            LOWER_HALF_ZONE: hit = (a[9] == 1'h0);
            LOWEST_PAGE_ZONE: hit = (a[9:4] == 6'h00);
            HIGHEST_PAGE_ZONE: hit = (a[9:4] == 6'h3F);
            default: hit = 1'h0;
        endcase
        return hit;
    endfunction : zone_locked

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    selk_pins_t sync1_q;
    selk_pins_t sync2_q;
    logic sck_prev_q;
    logic cs_prev_q;
    logic sck_rise;
    logic sck_fall;
    logic cs_rise;
    logic cs_fall;

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync1_q <= PINS_RST;
            sync2_q <= PINS_RST;
            sck_prev_q <= 1'h0;
            cs_prev_q <= 1'h0;
        end else begin
            sync1_q <= '{sck: i_sck, cs_n: i_cs_n, si: i_si, wp_n: i_wp_n};
            sync2_q <= sync1_q;
            sck_prev_q <= sync2_q.sck;
            cs_prev_q <= sync2_q.cs_n;
        end
    end

    assign sck_rise = sync2_q.sck && !sck_prev_q;
    assign sck_fall = !sync2_q.sck && sck_prev_q;
    assign cs_rise = sync2_q.cs_n && !cs_prev_q;
    assign cs_fall = !sync2_q.cs_n && cs_prev_q;

    // ------------------------------------------------------------
    // Array and page buffer
    // ------------------------------------------------------------
    logic [7:0] mem_q [MEM_DEPTH];
    logic [7:0] buf_q [PAGE_BYTES];
    logic [7:0] buf_d [PAGE_BYTES];

    // ------------------------------------------------------------
    // Instruction state
    // ------------------------------------------------------------
    selk_state_t st_q, st_d;
    logic [2:0] bit_q, bit_d;
    logic [7:0] sh_q, sh_d;
    logic [7:0] cmd_q, cmd_d;
    logic [9:0] addr_q, addr_d;
    logic abyte_q, abyte_d;
    logic [3:0] col_q, col_d;
    logic [15:0] mask_q, mask_d;
    logic [7:0] out_q, out_d;
    logic so_q, so_d;
    logic oe_q, oe_d;
    logic wel_q, wel_d;
    logic busy_q, busy_d;
    logic [TMR_W-1:0] tmr_q, tmr_d;
    logic nv_lock_q, nv_lock_d;
    logic [2:0] lock_pend_q, lock_pend_d;
    logic lock_got_q, lock_got_d;
    logic [2:0] lock_q, lock_d;
    logic [7:0] sh_in;
    logic [9:0] rd_addr;
    logic done;
    logic nv_ok;

    always_comb begin
        st_d = st_q;
        bit_d = bit_q;
        sh_d = sh_q;
        cmd_d = cmd_q;
        addr_d = addr_q;
        abyte_d = abyte_q;
        col_d = col_q;
        mask_d = mask_q;
        out_d = out_q;
        so_d = so_q;
        oe_d = oe_q;
        wel_d = wel_q;
        busy_d = busy_q;
        tmr_d = tmr_q;
        nv_lock_d = nv_lock_q;
        lock_pend_d = lock_pend_q;
        lock_got_d = lock_got_q;
        lock_d = lock_q;
        buf_d = buf_q;
        rd_addr = addr_q;
        sh_in = {sh_q[6:0], sync2_q.si};
        done = busy_q && (tmr_q == '0);
        nv_ok = !busy_q && (bit_q == 3'h0) && wel_q && sync2_q.wp_n;
        // Self-timed write cycle
        if (done) begin
            busy_d = 1'h0;
            wel_d = 1'h0;
            mask_d = '0;
            if (nv_lock_q) begin
                lock_d = lock_pend_q;
            end
        end else if (busy_q) begin
            tmr_d = tmr_q - 1'h1;
        end
        if (cs_fall) begin
            st_d = ST_OPC;
            bit_d = 3'h0;
        end else if (cs_rise) begin
            st_d = ST_OFF;
            oe_d = 1'h0;
            bit_d = 3'h0;
            case (st_q)
                ST_LATCH: begin
                    if (bit_q == 3'h0) begin
                        wel_d = (cmd_q == SET_WRITE_LATCH_CMD);
                    end
                end
                ST_WDATA: begin
                    if (nv_ok && (mask_q != '0)) begin
                        busy_d = 1'h1;
                        tmr_d = TMR_W'(P_WC_CYCLES - 1);
                        nv_lock_d = 1'h0;
                    end else begin
                        mask_d = '0;
                    end
                end
                ST_LOCK: begin
                    if (nv_ok && lock_got_q) begin
                        busy_d = 1'h1;
                        tmr_d = TMR_W'(P_WC_CYCLES - 1);
                        nv_lock_d = 1'h1;
                    end
                end
                default: begin
                end
            endcase
        end else if (sck_rise && (st_q != ST_OFF)) begin
            sh_d = sh_in;
            bit_d = bit_q + 3'h1;
            if (st_q == ST_LATCH) begin
                st_d = ST_IGN;
            end
            if (bit_q == 3'h7) begin
                case (st_q)
                    ST_OPC: begin
                        cmd_d = sh_in;
                        if (busy_q && (sh_in != READ_STATUS_CMD)) begin
                            st_d = ST_IGN;
                        end else begin
                            case (sh_in)
                                SET_WRITE_LATCH_CMD, CLEAR_WRITE_LATCH_CMD: st_d = ST_LATCH;
                                LOCK_CMD: begin
                                    st_d = wel_q ? ST_LOCK : ST_IGN;
                                    lock_got_d = 1'h0;
                                end
                                READ_STATUS_CMD: begin
                                    st_d = ST_STAT;
                                    out_d = {5'h00, lock_q};
                                end
                                WRITE_CMD: begin
                                    st_d = wel_q ? ST_ADDR : ST_IGN;
                                    abyte_d = 1'h0;
                                    mask_d = '0;
                                end
                                READ_CMD: begin
                                    st_d = ST_ADDR;
                                    abyte_d = 1'h0;
                                end
                                default: st_d = ST_IGN;
                            endcase
                        end
                    end
                    ST_ADDR: begin
                        if (!abyte_q) begin
                            addr_d[9:8] = sh_in[1:0];
                            abyte_d = 1'h1;
                        end else begin
                            addr_d[7:0] = sh_in;
                            col_d = sh_in[3:0];
                            rd_addr = {addr_q[9:8], sh_in};
                            out_d = mem_q[rd_addr];
                            st_d = (cmd_q == WRITE_CMD) ? ST_WDATA : ST_RDATA;
                        end
                    end
                    ST_WDATA: begin
                        buf_d[col_q] = sh_in;
                        mask_d[col_q] = 1'h1;
                        col_d = col_q + 4'h1;
                    end
                    ST_RDATA: begin
                        rd_addr = addr_q + 10'h001;
                        addr_d = rd_addr;
                        out_d = mem_q[rd_addr];
                    end
                    ST_STAT: out_d = {5'h00, lock_q};
                    ST_LOCK: begin
                        lock_pend_d = sh_in[2:0];
                        lock_got_d = 1'h1;
                    end
                    default: begin
                    end
                endcase
            end
        end else if (sck_fall && ((st_q == ST_RDATA) || (st_q == ST_STAT))) begin
            oe_d = 1'h1;
            so_d = (st_q == ST_STAT && busy_q) ? 1'h1 : out_q[7];
            out_d = {out_q[6:0], 1'h0};
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_q <= ST_OFF;
            bit_q <= 3'h0;
            sh_q <= 8'h00;
            cmd_q <= 8'h00;
            addr_q <= 10'h000;
            abyte_q <= 1'h0;
            col_q <= 4'h0;
            mask_q <= 16'h0000;
            out_q <= 8'h00;
            so_q <= 1'h0;
            oe_q <= 1'h0;
            wel_q <= 1'h0;
            busy_q <= 1'h0;
            tmr_q <= '0;
            nv_lock_q <= 1'h0;
            lock_pend_q <= LOCK_RST;
            lock_got_q <= 1'h0;
            lock_q <= LOCK_RST;
        end else begin
            st_q <= st_d;
            bit_q <= bit_d;
            sh_q <= sh_d;
            cmd_q <= cmd_d;
            addr_q <= addr_d;
            abyte_q <= abyte_d;
            col_q <= col_d;
            mask_q <= mask_d;
            out_q <= out_d;
            so_q <= so_d;
            oe_q <= oe_d;
            wel_q <= wel_d;
            busy_q <= busy_d;
            tmr_q <= tmr_d;
            nv_lock_q <= nv_lock_d;
            lock_pend_q <= lock_pend_d;
            lock_got_q <= lock_got_d;
            lock_q <= lock_d;
        end
    end

    // Page data holds no control state
    always_ff @(posedge i_ref_clk) begin
        buf_q <= buf_d;
    end

    // Commit page at end of write cycle, skipping protected bytes
    always_ff @(posedge i_ref_clk) begin
        if (done && !nv_lock_q) begin
            for (int i = 0; i < PAGE_BYTES; i++) begin
                if (mask_q[i] && !zone_locked(lock_q, {addr_q[9:4], 4'(i)})) begin
                    mem_q[{addr_q[9:4], 4'(i)}] <= buf_q[i];
                end
            end
        end
    end

    assign o_so = so_q;
    assign o_so_oe = oe_q;
    assign o_busy = busy_q;
    assign o_wel = wel_q;
    assign o_lock_select_bits = lock_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_n);

    AST_LOCK_NEEDS_WEL: assert property (
        $rose(busy_q) && nv_lock_q |-> $past(wel_q))
        else $error("lock write started without write latch");
    AST_LOCK_START: assert property (
        cs_rise && st_q == ST_LOCK && lock_got_q && nv_ok |=> busy_q && nv_lock_q)
        else $error("lock write did not start");
    AST_LOCK_COMMIT: assert property (
        busy_q && nv_lock_q && tmr_q == '0 |=> o_lock_select_bits == $past(lock_pend_q))
        else $error("last lock byte not committed");
    AST_STANDBY: assert property (
        st_q == ST_OFF |-> !o_so_oe)
        else $error("output driven in standby");
    AST_CS_FALL: assert property (
        cs_fall |=> st_q == ST_OPC && bit_q == 3'h0)
        else $error("frame not opened on select fall");
    AST_ABORT: assert property (
        cs_rise && bit_q != 3'h0 && !busy_q |=> !busy_q)
        else $error("write started off byte boundary");
    AST_WEL_SET: assert property (
        cs_rise && st_q == ST_LATCH && bit_q == 3'h0 && cmd_q == SET_WRITE_LATCH_CMD
        |=> o_wel)
        else $error("write latch not set");
    AST_WEL_CLR: assert property (
        cs_rise && st_q == ST_LATCH && bit_q == 3'h0 && cmd_q == CLEAR_WRITE_LATCH_CMD
        |=> !o_wel)
        else $error("write latch not cleared");
    AST_WIP_HIGH: assert property (
        sck_fall && st_q == ST_STAT && busy_q |=> o_so && o_so_oe)
        else $error("busy status not high");
    AST_WEL_AUTO_CLR: assert property (
        $fell(busy_q) |-> !o_wel)
        else $error("write latch kept after write cycle");
endmodule : selk_serial_lock

// *** test/selk_host_model.sv ***
// Host model: SPI mode 0 master driving the serial pins
`timescale 1ns/1ps
module selk_host_model (
    input wire logic i_ref_clk,
    input wire logic i_so,
    output logic o_sck,
    output logic o_cs_n,
    output logic o_si
);
    // ----
    // Pin timing, half period in clocks
    // ----
    int hp = 4;
    initial begin
        o_sck = 1'b0;
        o_cs_n = 1'b0;
        o_si = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge i_ref_clk);
    endtask : tick
    // Falling select opens a frame
    task automatic start();
        o_cs_n = 1'b1;
        tick(hp);
        o_cs_n = 1'b0;
        tick(hp);
    endtask : start
    // Sample late in the high phase
    task automatic shift(input logic [7:0] tx, input int nb, inout logic [7:0] rx);
        for (int i = 7; i > 7 - nb; i--) begin
            o_si = tx[i];
            tick(hp);
            o_sck = 1'b1;
            tick(hp);
            rx = {rx[6:0], i_so};
            o_sck = 1'b0;
        end
    endtask : shift
    // Released data line shows no stale value
    task automatic stop();
        tick(hp);
        o_cs_n = 1'b1;
        o_si = ~o_si;
        tick(8);
    endtask : stop
endmodule : selk_host_model

// *** test/selk_serial_lock_tb_top.sv ***
// Testbench: serial lock command logic driven through a host model
`timescale 1ns/1ps
module selk_serial_lock_tb_top;
    import selk_pkg::*;
    localparam int WC = 400;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wp_n = 1'b1;
    logic sck, cs_n, si, so, so_oe, busy, wel, so_line;
    logic so_last = 1'b0;
    logic [2:0] lock;
    logic [7:0] rx = 8'h00;
    logic [7:0] da, db, rd_v;
    logic [9:0] aa, ab;
    int num_errors = 0;
    int checks = 0;
    int cyc = 0;
    always #25 clk = ~clk;
    always @(posedge clk) if (so_oe === 1'b1) so_last <= so;
    assign so_line = (so_oe === 1'b1) ? so : ~so_last;
    selk_serial_lock #(.P_WC_CYCLES(WC)) u_selk_serial_lock (
        .i_ref_clk(clk), .i_rst_n(rst_n), .i_sck(sck), .i_cs_n(cs_n), .i_si(si),
        .i_wp_n(wp_n), .o_so(so), .o_so_oe(so_oe), .o_busy(busy), .o_wel(wel),
        .o_lock_select_bits(lock));
    selk_host_model u_selk_host_model (.i_ref_clk(clk), .i_so(so_line), .o_sck(sck),
        .o_cs_n(cs_n), .o_si(si));
    // ----
    // Checking and closing
    // ----
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic report_and_stop();
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            num_errors++;
            report_and_stop();
        end
    end
    // ----
    // Frame and operation helpers
    // ----
    task automatic frame(input logic [7:0] q[$], input int tail);
        u_selk_host_model.start();
        foreach (q[i]) u_selk_host_model.shift(q[i], 8, rx);
        if (tail > 0) u_selk_host_model.shift(8'hA5, tail, rx);
        u_selk_host_model.stop();
    endtask : frame
    task automatic wait_idle();
        int n = 0;
        while (busy !== 1'b0 && n < 2 * WC) begin
            @(negedge clk);
            n++;
        end
        chk("busy_end", {7'h00, busy}, 8'h00);
    endtask : wait_idle
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        frame('{SET_WRITE_LATCH_CMD}, 0);
        frame('{WRITE_CMD, {6'h00, a[9:8]}, a[7:0], d}, 0);
        chk("busy_wr", {7'h00, busy}, 8'h01);
        wait_idle();
        chk("wel_wr", {7'h00, wel}, 8'h00);
    endtask : wr
    task automatic rd(input logic [9:0] a, output logic [7:0] d);
        frame('{READ_CMD, {6'h00, a[9:8]}, a[7:0], 8'h00}, 0);
        d = rx;
        chk("oe_off", {7'h00, so_oe}, 8'h00);
    endtask : rd
    task automatic set_lock(input logic [2:0] c);
        logic [7:0] first;
        first = {5'h00, 3'($urandom)};
        frame('{SET_WRITE_LATCH_CMD}, 0);
        chk("wel_set", {7'h00, wel}, 8'h01);
        frame('{LOCK_CMD, first, {5'h00, c}}, 0);
        chk("busy_lock", {7'h00, busy}, 8'h01);
        frame('{READ_STATUS_CMD, 8'h00}, 0);
        chk("stat_busy", rx, 8'hFF);
        wait_idle();
        chk("wel_lock", {7'h00, wel}, 8'h00);
        chk("lock", {5'h00, lock}, {5'h00, c});
        frame('{READ_STATUS_CMD, 8'h00}, 0);
        chk("stat", rx, {5'h00, c});
    endtask : set_lock
    // ----
    // Main sequence
    // ----
    initial begin
        void'($urandom(32'h3108aa4c));
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        chk("rst", {2'h0, so_oe, busy, wel, lock}, 8'h00);
        u_selk_host_model.shift(SET_WRITE_LATCH_CMD, 8, rx);
        u_selk_host_model.stop();
        chk("no_fall", {7'h00, wel}, 8'h00);
        frame('{SET_WRITE_LATCH_CMD}, 1);
        chk("wel_9bit", {7'h00, wel}, 8'h00);
        frame('{SET_WRITE_LATCH_CMD}, 0);
        chk("wel_on", {7'h00, wel}, 8'h01);
        frame('{CLEAR_WRITE_LATCH_CMD}, 0);
        chk("wel_off", {7'h00, wel}, 8'h00);
        frame('{LOCK_CMD, 8'h03}, 0);
        chk("lock_nowel", {4'h0, busy, lock}, 8'h00);
        frame('{SET_WRITE_LATCH_CMD}, 0);
        frame('{LOCK_CMD, 8'h02}, 3);
        chk("lock_part", {4'h0, busy, lock}, 8'h00);
        frame('{CLEAR_WRITE_LATCH_CMD}, 0);
        for (int c = 7; c >= 0; c--) set_lock(3'(c));
        u_selk_host_model.hp = 6;
        aa = {2'b00, 8'($urandom)};
        ab = {2'b10, 8'($urandom)};
        da = 8'($urandom);
        db = 8'($urandom);
        wr(aa, da);
        wr(ab, db);
        rd(aa, rd_v);
        chk("rd_a", rd_v, da);
        rd(ab, rd_v);
        chk("rd_b", rd_v, db);
        set_lock(FIRST_QUARTER_ZONE);
        wr(aa, ~da);
        wr(ab, ~db);
        rd(aa, rd_v);
        chk("prot_a", rd_v, da);
        rd(ab, rd_v);
        chk("free_b", rd_v, ~db);
        report_and_stop();
    end
endmodule : selk_serial_lock_tb_top
